// ---- verilog/adc_port_pkg.sv ----
package adc_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BURST_LEN = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0C;
  localparam logic [7:0] OFF_INT_EN = 8'h10;
  localparam logic [7:0] OFF_INT_CLR = 8'h14;

  // Control word, shared with serial register 0
  localparam int CTRL_W = 24;
  localparam int CTRL_PDN = 0;
  localparam int CTRL_ALIGN_DIS = 1;
  localparam int CTRL_OVR_ALIGN = 2;
  localparam int CTRL_CLK_INV = 3;
  localparam int CTRL_B_ON_A = 4;
  localparam int CTRL_FEEDBACK = 5;
  localparam int CTRL_FOUR_PIN = 16;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 24'h000000;
  localparam logic [15:0] BURST_LEN_RESET = 16'h0040;

  // Status word fields
  localparam int ST_HIRES = 0;
  localparam int ST_READY = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_FOUR_PIN = 3;
  localparam int ST_ALIGNED = 4;

  // Interrupt bits
  localparam int INT_W = 4;
  localparam int INT_BURST_DONE = 0;
  localparam int INT_OVR_A = 1;
  localparam int INT_OVR_B = 2;
  localparam int INT_ALIGN = 3;

  // Data path
  localparam int SAMPLE_W = 12;
  localparam int LANE_W = SAMPLE_W + 1;
  localparam int LOWRES_DROP = 4;
  localparam int ALIGN_PERIOD_WORDS = 16;

  // Serial port framing: read flag, 7 address bits, 24 data bits
  localparam int SER_HDR_BITS = 8;
  localparam int SER_FRAME_BITS = 32;
  localparam logic [6:0] SER_ADDR_CTRL = 7'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIG_HOLDOFF_NS = 40;
  localparam int TRIG_HOLDOFF_CYC = (TRIG_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {BURST_IDLE, BURST_RUN, BURST_HOLD} burst_e;

  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
    logic ovr_a;
    logic ovr_b;
  } sample_s;

  typedef struct packed {
    logic stb;
    logic [CTRL_W-1:0] data;
  } ser_wr_s;

endpackage : adc_port_pkg

// ---- verilog/ddr_lane.sv ----
`timescale 1ns/1ps
module ddr_lane import adc_port_pkg::*; #(
  parameter int W = LANE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clk_inv,
  input wire logic clk_stop,
  input wire logic [W-1:0] word,
  output logic [W-1:0] data_r,
  output logic fwd_clk_r,
  output logic launch
);

  logic phase_r;
  logic tgl_r;
  logic tgl_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // A word lives two cycles; the clock edge lands in its middle
  assign launch = run & ~phase_r;
  assign tgl_nxt = phase_r ? ~tgl_r : tgl_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 1'b0;
      tgl_r <= 1'b0;
    end else if (!run) begin
      phase_r <= 1'b0;
      tgl_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
      tgl_r <= tgl_nxt;
    end
  end

  // New word on every clock edge, so two words per clock period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= '0;
    end else if (!run) begin
      data_r <= '0;
    end else if (launch) begin
      data_r <= word;
    end
  end

  // Polarity picks which edge sits at the word centre
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_clk_r <= 1'b0;
    end else if (!run || clk_stop) begin
      fwd_clk_r <= clk_inv;
    end else begin
      fwd_clk_r <= tgl_nxt ^ clk_inv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_launch_held;
    (launch && !clk_stop) ##1 (run && !clk_stop && $stable(clk_inv));
  endsequence

  word_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch ##1 run |=> $stable(data_r))
    else $error("lane word changed in its second cycle");

  ddr_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_launch_held |=> fwd_clk_r != $past(fwd_clk_r))
    else $error("lane clock missed the word centre");

endmodule : ddr_lane

// ---- verilog/serial_port.sv ----
`timescale 1ns/1ps
module serial_port import adc_port_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdio_in,
  input wire logic four_pin,
  input wire logic [CTRL_W-1:0] ctrl_rd,
  output ser_wr_s wr_r,
  output logic sdio_out_r,
  output logic sdio_oe_n_r,
  output logic read_out_r,
  output logic read_out_oe_n_r
);

  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic sclk_d_r;
  logic [5:0] cnt_r;
  logic [31:0] shin_r;
  logic [CTRL_W-1:0] shout_r;
  logic rd_r;
  logic rise;
  logic fall;
  logic sel;
  logic din;
  logic drive;

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from the host's domain, two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 3'h2;
      s2_r <= 3'h2;
      sclk_d_r <= 1'b0;
    end else begin
      s1_r <= {sdio_in, serial_select_n, sclk};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[0];
    end
  end

  assign rise = s2_r[0] & ~sclk_d_r;
  assign fall = ~s2_r[0] & sclk_d_r;
  assign sel = ~s2_r[1];
  assign din = s2_r[2];
  assign drive = sel & rd_r & (cnt_r >= 6'(SER_HDR_BITS));

  // Bit counter and input shifter; deselect aborts the frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      shin_r <= '0;
      rd_r <= 1'b0;
    end else if (!sel) begin
      cnt_r <= '0;
      rd_r <= 1'b0;
    end else if (rise && cnt_r < 6'(SER_FRAME_BITS)) begin
      cnt_r <= cnt_r + 6'h01;
      shin_r <= {shin_r[30:0], din};
      if (cnt_r == 6'h00) begin
        rd_r <= din;
      end
    end
  end

  // Read data loaded after the header, shifted on falling edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shout_r <= '0;
    end else if (sel && rise && cnt_r == 6'(SER_HDR_BITS - 1)) begin
      shout_r <= ({shin_r[5:0], din} == SER_ADDR_CTRL) ? ctrl_rd : '0;
    end else if (sel && fall && cnt_r > 6'(SER_HDR_BITS)) begin
      shout_r <= {shout_r[CTRL_W-2:0], 1'b0};
    end
  end

  // Write strobe on the last bit; only register 0 exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r <= '0;
    end else begin
      wr_r.stb <= sel & rise & ~rd_r & (cnt_r == 6'(SER_FRAME_BITS - 1))
                  & (shin_r[29:23] == SER_ADDR_CTRL);
      wr_r.data <= {shin_r[22:0], din};
    end
  end

  // Pin drivers: shared pin turns round in 3-pin mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdio_out_r <= 1'b0;
      sdio_oe_n_r <= 1'b1;
      read_out_r <= 1'b0;
      read_out_oe_n_r <= 1'b1;
    end else begin
      sdio_out_r <= shout_r[CTRL_W-1];
      sdio_oe_n_r <= ~(drive & ~four_pin);
      read_out_r <= shout_r[CTRL_W-1];
      read_out_oe_n_r <= ~four_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sdio_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (drive && !four_pin) |=> !sdio_oe_n_r)
    else $error("shared pin not driven during 3-pin read");

  sdio_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(four_pin) |-> sdio_oe_n_r)
    else $error("shared pin driven in 4-pin mode");

  sdo_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_out_oe_n_r == !$past(four_pin))
    else $error("read-out pin enable wrong for mode");

endmodule : serial_port

// ---- verilog/adc_output_port.sv ----
// Contract
// - The chip-enable pin is active high, and a control bit can also power the port down.
// - The serial port starts in 3-pin mode where one shared pin carries data both ways.
// - With control bit 16 of serial register 0 set, the shared pin is input only.
// - The read-out pin floats in 3-pin mode and drives read data in 4-pin mode.
// - Channel A sends its 12-bit sample on a DDR bus, bit 11 most significant.
// - Channel B sends its 12-bit sample on its own DDR bus, bit 11 most significant.
// - Bus A has a forwarded DDR clock whose centred edge polarity is programmable.
// - Bus B has its own forwarded clock, which may be stopped so bus A's clock serves.
// - An alignment output is driven for multi-converter sync and can be disabled.
// - Each bus has an over-range output, optionally carrying the alignment signal.
// - A ready output shows when a new burst request can be accepted.
// - The high-resolution indicator is high exactly while full 12-bit words are sent.
// - The alignment input is idle low; its first high resets the logic and starts alignment.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module adc_output_port import adc_port_pkg::*; #(
  parameter int BURST_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_enable,
  input wire sample_s sample_in,
  input wire logic align_in,
  input wire logic burst_request_in,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic serial_read_out_pin,
  output logic serial_read_out_oe_n,
  output logic [SAMPLE_W-1:0] chan_a_out_bus,
  output logic [SAMPLE_W-1:0] chan_b_out_bus,
  output logic chan_a_fwd_clock,
  output logic chan_b_fwd_clock,
  output logic chan_a_over_range,
  output logic chan_b_over_range,
  output logic align_out,
  output logic burst_request_ready,
  output logic hi_res_out,
  output logic irq
);

  logic [CTRL_W-1:0] ctrl_r;
  logic [BURST_W-1:0] burst_len_r;
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_en_r;
  logic [INT_W-1:0] int_ev;
  logic [2:0] pin1_r;
  logic [2:0] pin2_r;
  logic align_d_r;
  logic trig_d_r;
  logic align_rise;
  logic trig_rise;
  logic active;
  logic run_r;
  logic aligned_r;
  logic [$clog2(ALIGN_PERIOD_WORDS)-1:0] align_cnt_r;
  logic align_pulse;
  burst_e burst_st_r;
  logic [BURST_W-1:0] burst_cnt_r;
  logic [$clog2(TRIG_HOLDOFF_CYC+1)-1:0] hold_cnt_r;
  logic ready_r;
  logic hires_r;
  logic align_out_r;
  logic irq_r;
  logic feedback;
  logic [LANE_W-1:0] word_a;
  logic [LANE_W-1:0] word_b;
  logic [LANE_W-1:0] lane_a;
  logic [LANE_W-1:0] lane_b;
  logic launch_a;
  ser_wr_s ser_wr;
  logic apb_access;
  logic apb_wr;
  logic [31:0] rd_mux;
  logic rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs from outside: two flops, then edge detect on the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_r <= 3'h0;
      pin2_r <= 3'h0;
      align_d_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      pin1_r <= {burst_request_in, align_in, chip_enable};
      pin2_r <= pin1_r;
      align_d_r <= pin2_r[1];
      trig_d_r <= pin2_r[2];
    end
  end

  assign active = pin2_r[0] & ~ctrl_r[CTRL_PDN];
  assign align_rise = pin2_r[1] & ~align_d_r;
  assign trig_rise = pin2_r[2] & ~trig_d_r;
  assign feedback = ctrl_r[CTRL_FEEDBACK];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, answer from flops
  assign apb_access = psel & penable;
  assign apb_wr = apb_access & pwrite & pready;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (paddr)
      OFF_CTRL: rd_mux = {8'h00, ctrl_r};
      OFF_BURST_LEN: rd_mux = 32'(burst_len_r);
      OFF_STATUS: rd_mux = 32'({aligned_r, ctrl_r[CTRL_FOUR_PIN], active, ready_r, hires_r});
      OFF_INT_STAT: rd_mux = 32'(int_stat_r);
      OFF_INT_EN: rd_mux = 32'(int_en_r);
      OFF_INT_CLR: rd_mux = 32'h00000000;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access & ~pready;
      prdata <= (apb_access && !pready && !pwrite) ? rd_mux : 32'h00000000;
      pslverr <= apb_access & ~pready & ~rd_ok;
    end
  end

  // Control word: bus write beats a serial write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      burst_len_r <= BURST_W'(BURST_LEN_RESET);
      int_en_r <= '0;
    end else begin
      if (apb_wr && paddr == OFF_CTRL) begin
        ctrl_r <= pwdata[CTRL_W-1:0];
      end else if (ser_wr.stb) begin
        ctrl_r <= ser_wr.data;
      end
      if (apb_wr && paddr == OFF_BURST_LEN) begin
        burst_len_r <= pwdata[BURST_W-1:0];
      end
      if (apb_wr && paddr == OFF_INT_EN) begin
        int_en_r <= pwdata[INT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a new event wins over a clear in the same cycle
  assign int_ev[INT_BURST_DONE] = (burst_st_r == BURST_RUN) && launch_a
                                  && (burst_cnt_r <= BURST_W'(1));
  assign int_ev[INT_OVR_A] = active & sample_in.ovr_a;
  assign int_ev[INT_OVR_B] = active & sample_in.ovr_b;
  assign int_ev[INT_ALIGN] = align_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (apb_wr && paddr == OFF_INT_CLR) begin
        int_stat_r <= (int_stat_r & ~pwdata[INT_W-1:0]) | int_ev;
      end else begin
        int_stat_r <= int_stat_r | int_ev;
      end
      irq_r <= |(int_stat_r & int_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lanes run while enabled; an alignment rise drops them for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else begin
      run_r <= active & ~align_rise;
    end
  end

  // Alignment pulse train, one word in every period, restarted by the input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aligned_r <= 1'b0;
      align_cnt_r <= '0;
    end else if (align_rise) begin
      aligned_r <= 1'b1;
      align_cnt_r <= '0;
    end else if (aligned_r && launch_a) begin
      align_cnt_r <= align_cnt_r + 1'b1;
    end
  end

  assign align_pulse = aligned_r & (align_cnt_r == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_out_r <= 1'b0;
    end else begin
      align_out_r <= align_pulse & active & ~ctrl_r[CTRL_ALIGN_DIS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer: request only taken while ready; hold-off before re-arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_st_r <= BURST_IDLE;
      burst_cnt_r <= '0;
      hold_cnt_r <= '0;
    end else if (!run_r || !feedback) begin
      burst_st_r <= BURST_IDLE;
    end else begin
      case (burst_st_r)
        BURST_IDLE: begin
          if (trig_rise && ready_r) begin
            burst_st_r <= BURST_RUN;
            burst_cnt_r <= burst_len_r;
          end
        end
        BURST_RUN: begin
          if (launch_a) begin
            burst_cnt_r <= burst_cnt_r - 1'b1;
            if (burst_cnt_r <= BURST_W'(1)) begin
              burst_st_r <= BURST_HOLD;
              hold_cnt_r <= ($bits(hold_cnt_r))'(TRIG_HOLDOFF_CYC);
            end
          end
        end
        BURST_HOLD: begin
          if (hold_cnt_r <= ($bits(hold_cnt_r))'(1)) begin
            burst_st_r <= BURST_IDLE;
          end else begin
            hold_cnt_r <= hold_cnt_r - 1'b1;
          end
        end
        default: burst_st_r <= BURST_IDLE;
      endcase
    end
  end

  // Ready and resolution flags; outside a burst feedback words are cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b0;
      hires_r <= 1'b0;
    end else begin
      ready_r <= active & feedback & (burst_st_r == BURST_IDLE);
      hires_r <= run_r & (~feedback | (burst_st_r == BURST_RUN));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane words: top bit is over-range or the alignment pulse
  always_comb begin
    word_a[SAMPLE_W-1:0] = sample_in.a;
    word_b[SAMPLE_W-1:0] = sample_in.b;
    if (!hires_r) begin
      word_a[LOWRES_DROP-1:0] = '0;
      word_b[LOWRES_DROP-1:0] = '0;
    end
    word_a[SAMPLE_W] = ctrl_r[CTRL_OVR_ALIGN] ? align_pulse : sample_in.ovr_a;
    word_b[SAMPLE_W] = ctrl_r[CTRL_OVR_ALIGN] ? align_pulse : sample_in.ovr_b;
  end

  ddr_lane #(.W(LANE_W)) lane_a_u (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_r),
    .clk_inv(ctrl_r[CTRL_CLK_INV]),
    .clk_stop(1'b0),
    .word(word_a),
    .data_r(lane_a),
    .fwd_clk_r(chan_a_fwd_clock),
    .launch(launch_a)
  );

  // Bus B clock may be parked so the receiver uses the bus A clock
  ddr_lane #(.W(LANE_W)) lane_b_u (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_r),
    .clk_inv(ctrl_r[CTRL_CLK_INV]),
    .clk_stop(ctrl_r[CTRL_B_ON_A]),
    .word(word_b),
    .data_r(lane_b),
    .fwd_clk_r(chan_b_fwd_clock),
    .launch()
  );

  serial_port serial_u (
    .pclk(pclk),
    .presetn(presetn),
    .sclk(sclk),
    .serial_select_n(serial_select_n),
    .sdio_in(sdio_in),
    .four_pin(ctrl_r[CTRL_FOUR_PIN]),
    .ctrl_rd(ctrl_r),
    .wr_r(ser_wr),
    .sdio_out_r(sdio_out),
    .sdio_oe_n_r(sdio_oe_n),
    .read_out_r(serial_read_out_pin),
    .read_out_oe_n_r(serial_read_out_oe_n)
  );

  assign chan_a_out_bus = lane_a[SAMPLE_W-1:0];
  assign chan_b_out_bus = lane_b[SAMPLE_W-1:0];
  assign chan_a_over_range = lane_a[SAMPLE_W];
  assign chan_b_over_range = lane_b[SAMPLE_W];
  assign align_out = align_out_r;
  assign burst_request_ready = ready_r;
  assign hi_res_out = hires_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_burst_taken;
    trig_rise && ready_r && run_r && feedback;
  endsequence

  power_off_a: assert property (!active |=> !burst_request_ready && !run_r)
    else $error("port stayed active while disabled");
  b_clk_park_a: assert property ($past(ctrl_r[CTRL_B_ON_A])
    |-> chan_b_fwd_clock == $past(ctrl_r[CTRL_CLK_INV]))
    else $error("bus B clock ran while parked");
  align_dis_a: assert property (ctrl_r[CTRL_ALIGN_DIS] |=> !align_out)
    else $error("alignment output not disabled");
  ovr_route_a: assert property (run_r && launch_a && !sample_in.ovr_a
    && !ctrl_r[CTRL_OVR_ALIGN] |=> !chan_a_over_range)
    else $error("over-range flag without cause");
  trig_take_a: assert property (s_burst_taken |=> burst_st_r == BURST_RUN
    ##1 hi_res_out)
    else $error("burst request not taken");
  ready_busy_a: assert property (burst_st_r != BURST_IDLE |=> !burst_request_ready)
    else $error("ready shown during burst");
  hires_low_a: assert property (feedback && burst_st_r != BURST_RUN |=> !hi_res_out)
    else $error("high resolution flag outside burst");
  align_reset_a: assert property (align_rise |=> !run_r && aligned_r)
    else $error("alignment input did not reset lanes");

endmodule : adc_output_port

// ---- tb/rx_logic_model.sv ----
`timescale 1ns/1ps
module rx_logic_model import adc_port_pkg::*; (
  input wire logic [SAMPLE_W-1:0] chan_a_out_bus,
  input wire logic [SAMPLE_W-1:0] chan_b_out_bus,
  input wire logic chan_a_fwd_clock,
  input wire logic chan_b_fwd_clock,
  input wire logic rd_pin,
  output logic sclk,
  output logic serial_select_n,
  output logic host_sdio,
  output logic burst_request_in,
  output logic [SAMPLE_W-1:0] cap_a,
  output logic [SAMPLE_W-1:0] cap_b
);
  // Capture on both edges, the way a receiver latches DDR words
  always @(chan_a_fwd_clock) cap_a = chan_a_out_bus;
  always @(chan_b_fwd_clock) cap_b = chan_b_out_bus;

  // Idle: link clock parked low, data line at its pull-down level
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    host_sdio = 1'b0;
    burst_request_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first: read flag, address, data; sclk runs only inside it.
  // Starts off the pclk edge so the pin synchroniser never races the change.
  task ser_xfer(input logic rd, input logic [6:0] addr, input logic [CTRL_W-1:0] d,
                output logic [CTRL_W-1:0] q);
    logic [SER_FRAME_BITS-1:0] f;
    f = {rd, addr, d};
    q = '0;
    #2 serial_select_n = 1'b0;
    for (int i = SER_FRAME_BITS - 1; i >= 0; i--) begin
      host_sdio = f[i];
      #40 sclk = 1'b1;
      q = {q[CTRL_W-2:0], rd_pin}; // Last 24 rises hold the read data
      #40 sclk = 1'b0;
    end
    #40 serial_select_n = 1'b1;
    host_sdio = 1'b0;
    #40; // Select stays high between frames
  endtask : ser_xfer

  // Request a full-resolution burst; held long enough for the pin sync
  task fire();
    #2 burst_request_in = 1'b1;
    #100 burst_request_in = 1'b0;
  endtask : fire
endmodule : rx_logic_model

// ---- tb/test_dual_adc_output_port.sv ----
`timescale 1ns/1ps
module test_dual_adc_output_port;
  import adc_port_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, serial_select_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sdio_out, sdio_oe_n, host_sdio, ro_pin, ro_oe_n, a_clk, b_clk, a_ovr, b_ovr;
  logic align_out, rdy, hi_res_out, irq, trig, err, ce, sync_in;
  logic [CTRL_W-1:0] sq;
  logic [SAMPLE_W-1:0] a_bus, b_bus, cap_a, cap_b;
  sample_s smp;
  int n_errors, checks_done, cnt;
  wire sdio_wire = sdio_oe_n ? host_sdio : sdio_out; // Whoever enables drives

  adc_output_port adc_output_port_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_enable(ce), .sample_in(smp),
    .align_in(sync_in), .burst_request_in(trig), .sclk(sclk),
    .serial_select_n(serial_select_n), .sdio_in(sdio_wire), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .serial_read_out_pin(ro_pin), .serial_read_out_oe_n(ro_oe_n),
    .chan_a_out_bus(a_bus), .chan_b_out_bus(b_bus), .chan_a_fwd_clock(a_clk),
    .chan_b_fwd_clock(b_clk), .chan_a_over_range(a_ovr), .chan_b_over_range(b_ovr),
    .align_out(align_out), .burst_request_ready(rdy), .hi_res_out(hi_res_out), .irq(irq));

  rx_logic_model rx_logic_model_i (.chan_a_out_bus(a_bus), .chan_b_out_bus(b_bus),
    .chan_a_fwd_clock(a_clk), .chan_b_fwd_clock(b_clk), .sclk(sclk),
    .serial_select_n(serial_select_n), .host_sdio(host_sdio), .burst_request_in(trig),
    .cap_a(cap_a), .cap_b(cap_b), .rd_pin(ro_oe_n ? sdio_wire : ro_pin));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      finish_test();
    end
  endtask : apb

  // Bounded wait for a level; running out ends the run as a failure
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_hi

  task count_align(input int cyc);
    cnt = 0;
    repeat (cyc) begin
      @(posedge pclk);
      cnt += (align_out === 1'b1);
    end
  endtask : count_align

  ////////////////////////////////////////////////////////////////////////////
  task t_reset_regs();
    chk("ro_oe_n", 1, ro_oe_n);
    chk("sdio_oe_n", 1, sdio_oe_n);
    apb(0, OFF_CTRL, 0);
    chk("ctrl", 0, rd);
    apb(0, OFF_BURST_LEN, 0);
    chk("blen", 32'h00000040, rd);
    apb(1, 8'h40, 32'hFFFFFFFF);
    chk("unmapped err", 1, err);
  endtask : t_reset_regs

  // Receive mode: full words on both buses, bit order kept
  task t_lanes();
    repeat (40) @(posedge pclk);
    chk("bus a", smp.a, cap_a);
    chk("bus b", smp.b, cap_b);
    chk("hires rx", 1, hi_res_out);
    smp.ovr_b <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("ovr b", 1, b_ovr);
    chk("ovr a", 0, a_ovr);
    smp.ovr_b <= 1'b0;
    ce <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("off hires", 0, hi_res_out);
    chk("off bus a", 0, a_bus);
    ce <= 1'b1;
  endtask : t_lanes

  // Feedback burst: low resolution until requested, then full words and irq
  task t_burst();
    apb(1, OFF_CTRL, 32'h00000020);
    apb(1, OFF_BURST_LEN, 32'h00000010);
    apb(1, OFF_INT_EN, 32'h00000001);
    repeat (30) @(posedge pclk);
    chk("low res a", {smp.a[11:4], 4'h0}, cap_a);
    chk("hires idle", 0, hi_res_out);
    chk("ready idle", 1, rdy);
    rx_logic_model_i.fire();
    wait_hi(hi_res_out);
    repeat (10) @(posedge pclk);
    chk("burst a", smp.a, cap_a);
    chk("ready busy", 0, rdy);
    wait_hi(irq);
    apb(0, OFF_INT_STAT, 0);
    chk("stat done", 1, rd[INT_BURST_DONE]);
    apb(1, OFF_INT_CLR, 32'h00000001);
    repeat (3) @(posedge pclk);
    chk("irq clr", 0, irq);
    chk("ready back", 1, rdy);
  endtask : t_burst

  // 3-pin read back, serial write of register 0 selects 4-pin, 4-pin read back
  task t_four_pin();
    rx_logic_model_i.ser_xfer(1'b1, SER_ADDR_CTRL, 24'h000000, sq);
    chk("ser rd 3pin", 32'h00000020, sq);
    rx_logic_model_i.ser_xfer(1'b0, SER_ADDR_CTRL, 24'h010000, sq);
    repeat (10) @(posedge pclk);
    apb(0, OFF_CTRL, 0);
    chk("ctrl ser", 32'h00010000, rd);
    chk("sdio in only", 1, sdio_oe_n);
    chk("ro drives", 0, ro_oe_n);
    rx_logic_model_i.ser_xfer(1'b1, SER_ADDR_CTRL, 24'h000000, sq);
    chk("ser rd 4pin", 32'h00010000, sq);
  endtask : t_four_pin

  // Alignment pulse one word (2 cycles) every 16 words, then silenced, B clock parked
  task t_align();
    sync_in <= 1'b1;
    repeat (8) @(posedge pclk);
    count_align(96);
    chk("align pulses", 6, cnt);
    apb(1, OFF_CTRL, 32'h00010012);
    repeat (4) @(posedge pclk);
    count_align(64);
    chk("align off", 0, cnt);
    chk("b clk parked", 0, b_clk);
  endtask : t_align

  initial begin
    n_errors = 0;
    checks_done = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    {ce, sync_in} = 2'b10;
    smp = '{a: 12'hA5C, b: 12'h3E7, ovr_a: 1'b0, ovr_b: 1'b0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_lanes();
    t_burst();
    t_four_pin();
    t_align();
    finish_test();
  end
endmodule : test_dual_adc_output_port
